// [vtc_codec.sv]
// Purpose: Trellis codec top, encoder plus hard-decision trellis decoder
// Assumes: sym_stb pulses once per symbol period, spaced at least 20 cycles apart
// Notes: Strobes while busy are ignored
//
// Contract
// - Differential encoder xors input with previous outputs
// - Differential encoding by sixteen-entry lookup table
// - Differential decoding by sixteen-entry lookup table
// - Decoded bits follow the differential decode equations
// - Symbols two bits, states and transitions three
// - Three-bit delay register yields one redundant bit
// - Redundant bit is first delay before update
// - Previous differential output cleared at initialisation
// - Convolutional state cleared to zero at initialisation
// - Eight Hamming distances computed and held per symbol
// - One survivor per state, metric sums distances
// - Old metrics kept; new metrics in second buffer
// - Path metric seven bits wide
// - Initial metrics zero for state zero, else sixteen
// - Circular survivor memory, newest overwrites oldest column
// - Traceback depth is sixteen symbol periods
// - Store predecessor and transition per new state
// - Eight three-bit entries per survivor column
// - Decision uses preceding depth-minus-one periods only
// - One symbol in and one out per period
`timescale 1ns/10ps
module vtc_codec (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sym_stb,
  input wire logic [vtc_pkg::SYM_W-1:0] sym_in,
  input wire logic [vtc_pkg::TR_W-1:0] rx_tr,
  output logic [vtc_pkg::TR_W-1:0] tx_tr,
  output logic tx_valid,
  output logic [vtc_pkg::SYM_W-1:0] dec_sym,
  output logic dec_valid,
  output logic busy
);
  import vtc_pkg::*;

  // ----------------------------------------
  // Predecessor helper
  // ----------------------------------------
  // Predecessors of new state n are {n[0], k}
  function automatic logic [ST_W-1:0] pred_of(input logic [ST_W-1:0] n, input logic [SYM_W-1:0] k);
    return {n[0], k};
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  vtc_state_type seq_state;
  logic sym_take;
  logic [DIST_W-1:0] branch_distance_store [NUM_STATES];
  logic [PM_W-1:0] old_path_metric [NUM_STATES];
  logic [PM_W-1:0] next_path_metric [NUM_STATES];
  logic [PM_W-1:0] acs_metric [NUM_STATES];
  logic [ST_W-1:0] acs_pred [NUM_STATES];
  logic [TR_W-1:0] acs_tr [NUM_STATES];
  logic [ST_W-1:0] survivor_pred_state_mem [TB_DEPTH][NUM_STATES];
  logic [TR_W-1:0] survivor_transition_mem [TB_DEPTH][NUM_STATES];
  logic [TB_PTR_W-1:0] time_ptr;
  logic [TB_PTR_W-1:0] tb_col;
  logic [TB_PTR_W-1:0] tb_count;
  logic [ST_W-1:0] tb_state;
  logic [ST_W-1:0] best_state;
  logic norm_all;
  logic [TR_W-1:0] decided_tr;
  logic [SYM_W-1:0] prev_rx_pair;
  logic [SYM_W-1:0] recovered_sym;

  // ----------------------------------------
  // Strobe acceptance
  // ----------------------------------------
  assign sym_take = sym_stb && (seq_state == VTC_IDLE);

  // ----------------------------------------
  // Encoder
  // ----------------------------------------
  vtc_encoder u_encoder (
    .clk(clk),
    .rst_b(rst_b),
    .sym_take(sym_take),
    .sym_in(sym_in),
    .tx_tr(tx_tr),
    .tx_valid(tx_valid)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_state <= VTC_IDLE;
    end else begin
      case (seq_state)
        VTC_IDLE: begin
          if (sym_take) begin
            seq_state <= VTC_ACS;
          end
        end
        VTC_ACS: begin
          seq_state <= VTC_SWAP;
        end
        VTC_SWAP: begin
          seq_state <= VTC_TRACE;
        end
        VTC_TRACE: begin
          if (tb_count == TB_STEPS) begin
            seq_state <= VTC_EMIT;
          end
        end
        VTC_EMIT: begin
          seq_state <= VTC_IDLE;
        end
        default: begin
          seq_state <= VTC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Busy flag
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (sym_take) begin
      busy <= 1'b1;
    end else if (seq_state == VTC_EMIT) begin
      busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // Branch distances
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int t = 0; t < NUM_STATES; t++) begin
        branch_distance_store[t] <= '0;
      end
    end else if (sym_take) begin
      for (int t = 0; t < NUM_STATES; t++) begin
        branch_distance_store[t] <= vtc_hamming(rx_tr, TR_W'(t));
      end
    end
  end

  // ----------------------------------------
  // Add, compare, select
  // ----------------------------------------
  always_comb begin
    logic [ST_W-1:0] p;
    logic [TR_W-1:0] t;
    logic [PM_W-1:0] cand;
    p = NULL_STATE;
    t = '0;
    cand = '0;
    for (int n = 0; n < NUM_STATES; n++) begin
      acs_metric[n] = '1;
      acs_pred[n] = NULL_STATE;
      acs_tr[n] = '0;
      for (int k = 0; k < NUM_PRED; k++) begin
        p = pred_of(ST_W'(n), SYM_W'(k));
        t = vtc_branch_tr(p, ST_W'(n));
        cand = PM_W'(old_path_metric[p] + {5'h00, branch_distance_store[t]});
        if (k == 0 || cand < acs_metric[n]) begin
          acs_metric[n] = cand;
          acs_pred[n] = p;
          acs_tr[n] = t;
        end
      end
    end
  end

  // ----------------------------------------
  // Second metric buffer, filled while old metrics stand
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int n = 0; n < NUM_STATES; n++) begin
        next_path_metric[n] <= PM_INIT_ZERO;
      end
    end else if (seq_state == VTC_ACS) begin
      for (int n = 0; n < NUM_STATES; n++) begin
        next_path_metric[n] <= acs_metric[n];
      end
    end
  end

  // ----------------------------------------
  // Lowest new metric and renormalisation test
  // ----------------------------------------
  always_comb begin
    logic [PM_W-1:0] low;
    low = next_path_metric[0];
    best_state = NULL_STATE;
    norm_all = 1'b1;
    for (int n = 0; n < NUM_STATES; n++) begin
      if (next_path_metric[n] < low) begin
        low = next_path_metric[n];
        best_state = ST_W'(n);
      end
      norm_all = norm_all & next_path_metric[n][PM_NORM_BIT];
    end
  end

  // ----------------------------------------
  // Old metrics replaced only once all states are selected
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int n = 0; n < NUM_STATES; n++) begin
        old_path_metric[n] <= (n == 0) ? PM_INIT_ZERO : PM_INIT_OTHER;
      end
    end else if (seq_state == VTC_SWAP) begin
      for (int n = 0; n < NUM_STATES; n++) begin
        old_path_metric[n] <= next_path_metric[n];
        if (norm_all) begin
          old_path_metric[n][PM_NORM_BIT] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Survivor memories
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < TB_DEPTH; c++) begin
        for (int n = 0; n < NUM_STATES; n++) begin
          survivor_pred_state_mem[c][n] <= NULL_STATE;
          survivor_transition_mem[c][n] <= '0;
        end
      end
    end else if (seq_state == VTC_ACS) begin
      for (int n = 0; n < NUM_STATES; n++) begin
        survivor_pred_state_mem[time_ptr][n] <= acs_pred[n];
        survivor_transition_mem[time_ptr][n] <= acs_tr[n];
      end
    end
  end

  // ----------------------------------------
  // Circular column pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      time_ptr <= PTR_ZERO;
    end else if (seq_state == VTC_EMIT) begin
      time_ptr <= time_ptr + PTR_ONE;
    end
  end

  // ----------------------------------------
  // Traceback
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_col <= PTR_ZERO;
      tb_count <= PTR_ZERO;
      tb_state <= NULL_STATE;
    end else if (seq_state == VTC_SWAP) begin
      tb_col <= time_ptr;
      tb_count <= PTR_ZERO;
      tb_state <= best_state;
    end else if (seq_state == VTC_TRACE && tb_count != TB_STEPS) begin
      tb_state <= survivor_pred_state_mem[tb_col][tb_state];
      tb_col <= tb_col - PTR_ONE;
      tb_count <= tb_count + PTR_ONE;
    end
  end

  assign decided_tr = survivor_transition_mem[tb_col][tb_state];

  // ----------------------------------------
  // Differential decoding and output
  // ----------------------------------------
  vtc_diff_decoder u_diff_decoder (
    .prev_pair(prev_rx_pair),
    .cur_pair(decided_tr[SYM_W-1:0]),
    .symbol(recovered_sym)
  );

  // Decided symbol register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_rx_pair <= NULL_PAIR;
      dec_sym <= NULL_PAIR;
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= (seq_state == VTC_EMIT);
      if (seq_state == VTC_EMIT) begin
        prev_rx_pair <= decided_tr[SYM_W-1:0];
        dec_sym <= recovered_sym;
      end
    end
  end
endmodule

// [vtc_pkg.sv]
// Purpose: Shared constants, state codes and trellis functions for the trellis codec
// Assumes: Symbol, delay state and transition fields are little-endian vectors, first bit is MSB
// Notes: Delay state [2:0] = {first, second, third delay element}
package vtc_pkg;

  // ----------------------------------------
  // Widths and sizes
  // ----------------------------------------
  localparam int SYM_W = 2;
  localparam int ST_W = 3;
  localparam int TR_W = 3;
  localparam int NUM_STATES = 8;
  localparam int NUM_PRED = 4;
  localparam int DIST_W = 2;
  localparam int PM_W = 7;
  localparam int TB_PTR_W = 4;
  localparam int TB_DEPTH = 16;
  localparam int DIFF_TABLE_SIZE = 16;

  // ----------------------------------------
  // Reset values and metric limits
  // ----------------------------------------
  localparam logic [PM_W-1:0] PM_INIT_ZERO = 7'h00;
  localparam logic [PM_W-1:0] PM_INIT_OTHER = 7'h10;
  localparam logic [PM_W-1:0] MAX_PATH_METRIC = 7'h70;
  localparam int PM_NORM_BIT = 6;
  localparam logic [ST_W-1:0] NULL_STATE = 3'h0;
  localparam logic [SYM_W-1:0] NULL_PAIR = 2'h0;
  localparam logic [TB_PTR_W-1:0] TB_STEPS = 4'hF;
  localparam logic [TB_PTR_W-1:0] PTR_ZERO = 4'h0;
  localparam logic [TB_PTR_W-1:0] PTR_ONE = 4'h1;

  // ----------------------------------------
  // Decoder sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    VTC_IDLE = 3'b000,
    VTC_ACS = 3'b001,
    VTC_SWAP = 3'b010,
    VTC_TRACE = 3'b011,
    VTC_EMIT = 3'b100
  } vtc_state_type;

  // ----------------------------------------
  // Trellis functions
  // ----------------------------------------
  // Next delay state from present state and differential pair
  function automatic logic [ST_W-1:0] vtc_next_state(input logic [ST_W-1:0] s, input logic [SYM_W-1:0] y);
    logic [ST_W-1:0] n;
    n[2] = y[0] ^ s[1] ^ (s[2] & y[1]);
    n[1] = y[1] ^ y[0] ^ s[0] ^ (s[2] & (y[0] ^ s[1]));
    n[0] = s[2];
    return n;
  endfunction

  // Transition of the branch from past state p to new state n
  function automatic logic [TR_W-1:0] vtc_branch_tr(input logic [ST_W-1:0] p, input logic [ST_W-1:0] n);
    logic [TR_W-1:0] t;
    t = {p[2], NULL_PAIR};
    for (int y = 0; y < NUM_PRED; y++) begin
      if (vtc_next_state(p, SYM_W'(y)) == n) begin
        t = {p[2], SYM_W'(y)};
      end
    end
    return t;
  endfunction

  // Hamming distance between two transitions
  function automatic logic [DIST_W-1:0] vtc_hamming(input logic [TR_W-1:0] a, input logic [TR_W-1:0] b);
    logic [TR_W-1:0] x;
    x = a ^ b;
    return DIST_W'({1'b0, x[0]} + {1'b0, x[1]} + {1'b0, x[2]});
  endfunction

  // Differential encode: {prev y1 y2, q1 q2} -> new y1 y2
  function automatic logic [SYM_W-1:0] vtc_diff_enc(input logic [3:0] idx);
    return {idx[1] ^ idx[3], (idx[1] & idx[3]) ^ idx[2] ^ idx[0]};
  endfunction

  // Differential decode: {prev y1 y2, cur y1 y2} -> q1 q2
  function automatic logic [SYM_W-1:0] vtc_diff_dec(input logic [3:0] idx);
    logic q1;
    q1 = idx[1] ^ idx[3];
    return {q1, (q1 & idx[3]) ^ idx[2] ^ idx[0]};
  endfunction

endpackage

// [vtc_encoder.sv]
// Purpose: Differential encoder plus rate 2/3 eight-state convolutional encoder
// Assumes: sym_take is a one-cycle pulse, at most one per symbol period
// Notes: Transition and valid are registered
`timescale 1ns/10ps
module vtc_encoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sym_take,
  input wire logic [vtc_pkg::SYM_W-1:0] sym_in,
  output logic [vtc_pkg::TR_W-1:0] tx_tr,
  output logic tx_valid
);
  import vtc_pkg::*;

  logic [SYM_W-1:0] prev_diff_output;
  logic [ST_W-1:0] conv_state_register;
  logic [SYM_W-1:0] diff_encode_table [DIFF_TABLE_SIZE];
  logic [SYM_W-1:0] diff_now;

  // ----------------------------------------
  // Differential encoding table
  // ----------------------------------------
  for (genvar i = 0; i < DIFF_TABLE_SIZE; i++) begin : g_enc_tab
    assign diff_encode_table[i] = vtc_diff_enc(4'(i));
  end
  assign diff_now = diff_encode_table[{prev_diff_output, sym_in}];

  // ----------------------------------------
  // Encoder state
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_diff_output <= NULL_PAIR;
      conv_state_register <= NULL_STATE;
    end else if (sym_take) begin
      prev_diff_output <= diff_now;
      conv_state_register <= vtc_next_state(conv_state_register, diff_now);
    end
  end

  // ----------------------------------------
  // Transition output
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_tr <= {1'b0, NULL_PAIR};
      tx_valid <= 1'b0;
    end else begin
      tx_valid <= sym_take;
      if (sym_take) begin
        tx_tr <= {conv_state_register[ST_W-1], diff_now};
      end
    end
  end
endmodule

// [vtc_diff_decoder.sv]
// Purpose: Differential decoder lookup
// Assumes: Pairs are lower two transition bits of the decided path
// Notes: Purely combinational
`timescale 1ns/10ps
module vtc_diff_decoder (
  input wire logic [vtc_pkg::SYM_W-1:0] prev_pair,
  input wire logic [vtc_pkg::SYM_W-1:0] cur_pair,
  output logic [vtc_pkg::SYM_W-1:0] symbol
);
  import vtc_pkg::*;

  logic [SYM_W-1:0] diff_decode_table [DIFF_TABLE_SIZE];

  // ----------------------------------------
  // Table and lookup
  // ----------------------------------------
  for (genvar i = 0; i < DIFF_TABLE_SIZE; i++) begin : g_dec_tab
    assign diff_decode_table[i] = vtc_diff_dec(4'(i));
  end
  assign symbol = diff_decode_table[{prev_pair, cur_pair}];
endmodule

// [vtc_channel.sv]
// Purpose: Far-side channel model, loops each sent transition back to the receiver
// Assumes: One transition per symbol period, noiseless line
// Notes: Received transition lags the sent one by one strobe
`timescale 1ns/10ps
module vtc_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [vtc_pkg::TR_W-1:0] tx_tr,
  input wire logic tx_valid,
  output logic [vtc_pkg::TR_W-1:0] rx_tr
);
  import vtc_pkg::*;
  // ----------------------------------------
  // Loopback
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_tr <= 3'h0;
    end else if (tx_valid) begin
      rx_tr <= tx_tr;
    end
  end
endmodule

// [vtc_codec_assertions.sv]
// Purpose: Port-level checker for the trellis codec
// Assumes: Strobes spaced by at least 21 cycles
// Notes: Bound into every codec instance
`timescale 1ns/10ps
module vtc_codec_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sym_stb,
  input wire logic [vtc_pkg::SYM_W-1:0] sym_in,
  input wire logic [vtc_pkg::TR_W-1:0] rx_tr,
  input wire logic [vtc_pkg::TR_W-1:0] tx_tr,
  input wire logic tx_valid,
  input wire logic [vtc_pkg::SYM_W-1:0] dec_sym,
  input wire logic dec_valid,
  input wire logic busy
);
  import vtc_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence take_s;
    sym_stb && !busy && !dec_valid;
  endsequence
  sequence busy_run_s;
    busy [*8];
  endsequence
  tx_answer_a: assert property (take_s |=> tx_valid ##1 !tx_valid) else $error("tx pulse missing");
  tx_cause_a: assert property (tx_valid |-> $past(sym_stb) && !$past(busy)) else $error("tx without strobe");
  dec_delay_a: assert property (take_s |-> ##20 dec_valid) else $error("decision late");
  busy_span_a: assert property (take_s |=> busy_run_s ##11 busy) else $error("busy dropped");
  dec_clear_a: assert property (dec_valid |-> !busy && $past(busy)) else $error("busy at decision");
  strobe_refused_a: assert property (sym_stb && busy |=> !tx_valid) else $error("busy strobe taken");
  tx_hold_a: assert property (!tx_valid |-> $stable(tx_tr)) else $error("tx changed");
  dec_hold_a: assert property (!dec_valid |-> $stable(dec_sym)) else $error("dec changed");
  refused_c: cover property (sym_stb && busy);
endmodule

bind vtc_codec vtc_codec_checker u_chk (.clk(clk), .rst_b(rst_b), .sym_stb(sym_stb), .sym_in(sym_in),
  .rx_tr(rx_tr), .tx_tr(tx_tr), .tx_valid(tx_valid), .dec_sym(dec_sym), .dec_valid(dec_valid), .busy(busy));

// [testbench.sv]
// Purpose: Self-checking bench for the trellis codec
// Assumes: Noiseless loopback channel
// Notes: Decoded symbol lags the sent one by sixteen strobes
`timescale 1ns/10ps
module testbench;
  import vtc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sym_stb = 1'b0;
  logic [SYM_W-1:0] sym_in = 2'h0;
  logic [TR_W-1:0] rx_tr;
  logic [TR_W-1:0] tx_tr;
  logic tx_valid;
  logic [SYM_W-1:0] dec_sym;
  logic dec_valid;
  logic busy;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rng = 32'h63;
  logic [ST_W-1:0] st;
  logic [SYM_W-1:0] prev;
  logic [TR_W-1:0] tr_q[$];
  logic [SYM_W-1:0] dec_q[$];
  logic [SYM_W-1:0] sent[$];

  always #25 clk = ~clk;

  vtc_codec dut (.clk(clk), .rst_b(rst_b), .sym_stb(sym_stb), .sym_in(sym_in), .rx_tr(rx_tr),
    .tx_tr(tx_tr), .tx_valid(tx_valid), .dec_sym(dec_sym), .dec_valid(dec_valid), .busy(busy));
  vtc_channel far_end (.clk(clk), .rst_b(rst_b), .tx_tr(tx_tr), .tx_valid(tx_valid), .rx_tr(rx_tr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic reset_dut;
    @(negedge clk);
    rst_b = 1'b0;
    tr_q.delete();
    dec_q.delete();
    sent.delete();
    st = 3'h0;
    prev = 2'h0;
    repeat (3) @(negedge clk);
    check({tx_tr, dec_sym, tx_valid, dec_valid, busy}, 8'h00);
    rst_b = 1'b1;
  endtask

  // Taken strobe, sometimes followed by a refused one
  task automatic send(input logic [SYM_W-1:0] q);
    logic y1;
    logic y2;
    int gap;
    y1 = q[1] ^ prev[1];
    y2 = (q[1] & prev[1]) ^ prev[0] ^ q[0];
    tr_q.push_back({st[2], y1, y2});
    st = {y2 ^ st[1] ^ (st[2] & y1), y1 ^ y2 ^ st[0] ^ (st[2] & (y2 ^ st[1])), st[2]};
    prev = {y1, y2};
    sent.push_back(q);
    dec_q.push_back(sent.size() > 16 ? sent[sent.size() - 17] : 2'h0);
    sym_in = q;
    sym_stb = 1'b1;
    @(negedge clk);
    sym_stb = 1'b0;
    rng = xorshift(rng);
    gap = 21 + int'(rng[1:0]);
    if (rng[2]) begin
      repeat (int'(rng[6:3]) + 1) @(negedge clk);
      sym_in = ~q;
      sym_stb = 1'b1;
      @(negedge clk);
      sym_stb = 1'b0;
      gap = gap - int'(rng[6:3]) - 2;
    end
    repeat (gap) @(negedge clk);
  endtask

  // ----------------------------------------
  // Monitor and sequence
  // ----------------------------------------
  always @(negedge clk) begin
    if (tx_valid === 1'b1) begin
      check(8'(tx_tr), 8'(tr_q.size() > 0 ? tr_q.pop_front() : 3'bx));
    end
    if (dec_valid === 1'b1) begin
      check(8'(dec_sym), 8'(dec_q.size() > 0 ? dec_q.pop_front() : 2'bx));
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 8000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (2) begin
      reset_dut();
      repeat (40) begin
        rng = xorshift(rng);
        send(rng[9:8]);
      end
    end
    check(8'(tr_q.size() + dec_q.size()), 8'h00);
    finish_test();
  end
endmodule
